// File: pkg/slot_ctrl_pkg.sv
// slot_ctrl_pkg: register indices, field positions, reset values and codes
// for the two-slot power and interrupt control block.
// assumes a 32-bit AHB-Lite register bus; byte address = 4 * index.
`default_nettype none
package slot_ctrl_pkg;
  localparam int SLOTS = 2;
  localparam int IDX_W = 8;
  // register indices, slot A in [0], slot B in [1]
  localparam logic [1:0][7:0] IDX_SC = {8'h44, 8'h04}; // status change
  localparam logic [1:0][7:0] IDX_VC = {8'h57, 8'h17}; // voltage control
  localparam logic [1:0][7:0] IDX_GC = {8'h5E, 8'h1E}; // global control
  localparam logic [1:0][7:0] IDX_MC = {8'h66, 8'h26}; // memory strobe ctl
  // voltage control fields
  localparam int VC_PD_SEL = 7;
  localparam int VC_SENSE1 = 4;
  localparam int VC_SENSE0 = 3;
  localparam int VC_THRESH = 2;
  localparam int VC_SUP_HI = 1;
  localparam int VC_SUP_LO = 0;
  localparam logic [7:0] VC_WMASK = 8'h87;
  // global control fields
  localparam int GC_PULSE = 3;
  localparam int GC_W1C = 2;
  localparam int GC_LEVEL = 1;
  localparam int GC_PD_EN = 0;
  localparam logic [7:0] GC_WMASK = 8'h0F;
  // memory strobe control fields
  localparam int MC_INHIBIT = 0;
  localparam int MC_WIDE = 7;
  localparam logic [7:0] MC_WMASK = 8'h81;
  // status change width
  localparam int SC_W = 4;
  // reset values
  localparam logic [7:0] VC_RST = 8'h00;
  localparam logic [7:0] GC_RST = 8'h00;
  localparam logic [7:0] MC_RST = 8'h00;
  localparam logic [3:0] SC_RST = 4'h0;
  // supply codes
  localparam logic [1:0] SUP_5V0 = 2'b10;
  localparam logic [1:0] SUP_3V3 = 2'b11;
endpackage
`default_nettype wire

// File: hdl/strobe_sync.sv
// strobe_sync: card write / output-enable strobe path for one slot.
// assumes host strobes are active low and synchronous to clk, and that
// busClkFall is a one-cycle pulse at each falling host bus clock edge.
`timescale 1ns/100ps
`default_nettype none
module strobe_sync
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic busClkFall,
  input wire logic bypass,
  input wire logic memWrite_b,
  input wire logic memRead_b,
  output logic cardWe_b,
  output logic cardOe_b
);
  logic weSync_q;
  logic oeSync_q;

  // one synchroniser stage taken at the host clock falling edge
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      weSync_q <= 1'b1;
      oeSync_q <= 1'b1;
    end
    else if (enable && busClkFall)
    begin
      weSync_q <= memWrite_b;
      oeSync_q <= memRead_b;
    end
  end

  // bypass is a straight path so the 8-bit case adds no latency
  assign cardWe_b = bypass ? memWrite_b : weSync_q;
  assign cardOe_b = bypass ? memRead_b : oeSync_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  AST_SYNC_STROBE: assert property (
    (!bypass && enable && busClkFall) ##1 !bypass |->
      cardWe_b == $past(memWrite_b) && cardOe_b == $past(memRead_b))
    else $error("synchronised strobe missed the falling edge sample");
  AST_BYPASS_STROBE: assert property (
    bypass |-> cardWe_b == memWrite_b && cardOe_b == memRead_b)
    else $error("bypassed strobe not following host strobe");
endmodule
`default_nettype wire

// File: hdl/slot_power_and_interrupt_control.sv
// slot_power_and_interrupt_control: per-slot voltage, global and status
// change registers of a two-slot card adapter, over AHB-Lite.
// assumes one AHB-Lite master, word transfers, all pins synchronous to clk.
// Behaviour
// - 16-bit window, inhibit 0: strobes pass one sync stage at host fall
// - inhibit 1 or 8-bit window: strobes follow host strobes directly
// - power-down select set while power-down enabled enters power-down
// - power-down halts logic; voltage control stays readable and writable
// - voltage control bits 4 and 3 show sense inputs 1 and 0
// - voltage control bit 2 drives the 5 V TTL threshold select
// - supply code 10 raises 5 V enable, 11 raises 3.3 V enable
// - global bit 3 gives pulse interrupts only in edge mode
// - in write-one-to-clear mode writing 1 clears flag and interrupt
// - disabled status sources clear their flag and interrupt outside power-down
// - global bit 1 selects level (1) or edge (0) interrupt signalling
// - global bit 0 permits power-down; 0 forbids it
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module slot_power_and_interrupt_control
#(
  parameter int NSLOT = 2
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic hostBusClock,
  input wire logic hostMemoryWriteStrobe_b,
  input wire logic hostMemoryReadStrobe_b,
  input wire logic [NSLOT-1:0] hostSlotHit,
  output logic [NSLOT-1:0] cardWriteEnable_b,
  output logic [NSLOT-1:0] cardOutputEnable_b,
  input wire logic [NSLOT-1:0] voltageSenseInput1,
  input wire logic [NSLOT-1:0] voltageSenseInput0,
  output logic [NSLOT-1:0] threshold5v,
  output logic [NSLOT-1:0] supply5vEnable,
  output logic [NSLOT-1:0] supply3v3Enable,
  output logic [NSLOT-1:0] powerDown,
  input wire logic [NSLOT-1:0][3:0] statusEvent,
  input wire logic [NSLOT-1:0][3:0] statusSourceEnable,
  output logic [NSLOT-1:0] hostIrq
);
  logic [NSLOT-1:0][7:0] vc_q;
  logic [NSLOT-1:0][7:0] gc_q;
  logic [NSLOT-1:0][7:0] mc_q;
  logic [NSLOT-1:0][3:0] sc_q;
  logic [NSLOT-1:0][3:0] sc_d;
  logic [NSLOT-1:0] irq_q;
  logic [NSLOT-1:0] irq_d;
  logic [NSLOT-1:0] pd;
  logic dRead_q;
  logic dWrite_q;
  logic rdWait_q;
  logic [7:0] dIdx_q;
  logic [31:0] rdata_q;
  logic [31:0] rdMux;
  logic busClk_q;
  logic busClkFall;
  logic addrTake;
  logic rdFire;
  logic wrFire;
  logic [7:0] wbyte;

  // address phase accepted only on an active transfer with hready high
  assign addrTake = hsel && htrans[1] && hready;
  // a read takes one wait state so its data and side effect come from flops
  assign rdFire = dRead_q && !rdWait_q;
  assign wrFire = dWrite_q;
  assign wbyte = hwdata[7:0];
  assign hreadyout = !rdFire;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // bus data-phase tracking
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dRead_q <= 1'b0;
      dWrite_q <= 1'b0;
      rdWait_q <= 1'b0;
      dIdx_q <= 8'h00;
    end
    else if (ce)
    begin
      if (rdFire)
        rdWait_q <= 1'b1;
      else if (hreadyout)
      begin
        dRead_q <= addrTake && !hwrite;
        dWrite_q <= addrTake && hwrite;
        dIdx_q <= haddr[9:2];
        rdWait_q <= 1'b0;
      end
    end
  end

  // read multiplexer; unmapped indices read as zero
  always_comb
  begin
    rdMux = 32'h0000_0000;
    for (int s = 0; s < NSLOT; s++)
    begin
      if (dIdx_q == slot_ctrl_pkg::IDX_VC[s])
      begin
        rdMux[7:0] = vc_q[s] & slot_ctrl_pkg::VC_WMASK;
        rdMux[slot_ctrl_pkg::VC_SENSE1] = voltageSenseInput1[s];
        rdMux[slot_ctrl_pkg::VC_SENSE0] = voltageSenseInput0[s];
      end
      if (dIdx_q == slot_ctrl_pkg::IDX_GC[s])
        rdMux[7:0] = gc_q[s];
      if (dIdx_q == slot_ctrl_pkg::IDX_MC[s])
        rdMux[7:0] = mc_q[s];
      if (dIdx_q == slot_ctrl_pkg::IDX_SC[s])
        rdMux[3:0] = sc_q[s];
    end
  end

  // read data register, loaded in the wait cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_q <= 32'h0000_0000;
    else if (ce && rdFire)
      rdata_q <= rdMux;
  end

  // voltage control keeps working in power-down so software can leave it
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      vc_q <= {NSLOT{slot_ctrl_pkg::VC_RST}};
    else if (ce && wrFire)
    begin
      for (int s = 0; s < NSLOT; s++)
        if (dIdx_q == slot_ctrl_pkg::IDX_VC[s])
          vc_q[s] <= wbyte & slot_ctrl_pkg::VC_WMASK;
    end
  end

  // global and strobe control registers halt with their slot
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gc_q <= {NSLOT{slot_ctrl_pkg::GC_RST}};
      mc_q <= {NSLOT{slot_ctrl_pkg::MC_RST}};
    end
    else if (ce && wrFire)
    begin
      for (int s = 0; s < NSLOT; s++)
      begin
        if (dIdx_q == slot_ctrl_pkg::IDX_GC[s] && !pd[s])
          gc_q[s] <= wbyte & slot_ctrl_pkg::GC_WMASK;
        if (dIdx_q == slot_ctrl_pkg::IDX_MC[s] && !pd[s])
          mc_q[s] <= wbyte & slot_ctrl_pkg::MC_WMASK;
      end
    end
  end

  // power-down needs both select and enable; order is software's job
  always_comb
  begin
    for (int s = 0; s < NSLOT; s++)
      pd[s] = vc_q[s][slot_ctrl_pkg::VC_PD_SEL] &&
              gc_q[s][slot_ctrl_pkg::GC_PD_EN];
  end
  assign powerDown = pd;

  // pins driven straight from voltage control bits
  always_comb
  begin
    for (int s = 0; s < NSLOT; s++)
    begin
      threshold5v[s] = vc_q[s][slot_ctrl_pkg::VC_THRESH];
      supply5vEnable[s] = vc_q[s][1:0] == slot_ctrl_pkg::SUP_5V0;
      supply3v3Enable[s] = vc_q[s][1:0] == slot_ctrl_pkg::SUP_3V3;
    end
  end

  // status change next state: set beats clear, disabled sources drop out
  always_comb
  begin
    for (int s = 0; s < NSLOT; s++)
    begin
      logic [3:0] clr;
      logic [3:0] set;
      clr = 4'h0;
      set = statusEvent[s] & statusSourceEnable[s];
      if (wrFire && dIdx_q == slot_ctrl_pkg::IDX_SC[s] &&
          gc_q[s][slot_ctrl_pkg::GC_W1C])
        clr = wbyte[3:0];
      if (rdFire && dIdx_q == slot_ctrl_pkg::IDX_SC[s] &&
          !gc_q[s][slot_ctrl_pkg::GC_W1C])
        clr = 4'hF;
      sc_d[s] = ((sc_q[s] & ~clr) | set) & statusSourceEnable[s];
    end
  end

  // interrupt: level follows pending; pulse marks a fresh flag only
  always_comb
  begin
    for (int s = 0; s < NSLOT; s++)
    begin
      if (!gc_q[s][slot_ctrl_pkg::GC_LEVEL] &&
          gc_q[s][slot_ctrl_pkg::GC_PULSE])
        irq_d[s] = |(sc_d[s] & ~sc_q[s]);
      else
        irq_d[s] = |sc_d[s];
    end
  end

  // status and interrupt state, frozen in power-down
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sc_q <= {NSLOT{slot_ctrl_pkg::SC_RST}};
      irq_q <= '0;
    end
    else if (ce)
    begin
      for (int s = 0; s < NSLOT; s++)
        if (!pd[s])
        begin
          sc_q[s] <= sc_d[s];
          irq_q[s] <= irq_d[s];
        end
    end
  end
  assign hostIrq = irq_q;

  // host bus clock is synchronous; keep last level for falling edge
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      busClk_q <= 1'b0;
    else if (ce)
      busClk_q <= hostBusClock;
  end
  assign busClkFall = busClk_q && !hostBusClock;

  // one strobe path per slot; only a hit slot sees the host strobes
  for (genvar g = 0; g < NSLOT; g++)
  begin : gSlot
    strobe_sync strobe_sync_inst
    (
      .clk(clk),
      .rst_b(rst_b),
      .enable(ce && !pd[g]),
      .busClkFall(busClkFall),
      .bypass(mc_q[g][slot_ctrl_pkg::MC_INHIBIT] ||
              !mc_q[g][slot_ctrl_pkg::MC_WIDE]),
      .memWrite_b(hostMemoryWriteStrobe_b || !hostSlotHit[g]),
      .memRead_b(hostMemoryReadStrobe_b || !hostSlotHit[g]),
      .cardWe_b(cardWriteEnable_b[g]),
      .cardOe_b(cardOutputEnable_b[g])
    );
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  AST_PD_ENTER: assert property (
    vc_q[0][7] && gc_q[0][0] |-> powerDown[0])
    else $error("power-down not entered");
  AST_PD_GATE: assert property (
    !gc_q[0][0] |-> !powerDown[0])
    else $error("power-down without enable");
  AST_PD_FREEZE: assert property (
    powerDown[0] && $past(powerDown[0]) |-> $stable(sc_q[0]) &&
      $stable(gc_q[0]))
    else $error("slot logic moved in power-down");
  AST_SENSE_READ: assert property (
    ce && rdFire && dIdx_q == 8'h17 ##1 1'b1 |->
      hrdata[4:3] == $past({voltageSenseInput1[0], voltageSenseInput0[0]}))
    else $error("sense bits not shown on read");
  AST_THRESH: assert property (
    threshold5v[1] == vc_q[1][2])
    else $error("threshold select wrong");
  AST_SUPPLY: assert property (
    vc_q[0][1] == 1'b0 |-> !supply5vEnable[0] && !supply3v3Enable[0])
    else $error("supply enabled for code 00 or 01");
  AST_SUPPLY_3V3: assert property (
    vc_q[0][1:0] == 2'b11 |-> supply3v3Enable[0] && !supply5vEnable[0])
    else $error("3.3 V code wrong");
  AST_LEVEL_IRQ: assert property (
    ce && !pd[0] && gc_q[0][1] ##1 gc_q[0][1] |-> hostIrq[0] == |sc_q[0])
    else $error("level irq not following pending flags");
  AST_READ_CLEAR: assert property (
    ce && !pd[0] && rdFire && dIdx_q == 8'h04 && !gc_q[0][2] &&
      statusEvent[0] == 4'h0 |=> sc_q[0] == 4'h0)
    else $error("read did not clear status change");
  AST_READ_KEEP: assert property (
    ce && !pd[0] && rdFire && dIdx_q == 8'h04 && gc_q[0][2] &&
      statusSourceEnable[0] == 4'hF && statusEvent[0] == 4'h0 |=>
      sc_q[0] == $past(sc_q[0]))
    else $error("read cleared status in write-one mode");
  AST_W1C: assert property (
    ce && !pd[0] && wrFire && dIdx_q == 8'h04 && gc_q[0][2] &&
      statusEvent[0] == 4'h0 |=> (sc_q[0] & $past(wbyte[3:0])) == 4'h0)
    else $error("write one did not clear flag");
  AST_DISABLED: assert property (
    ce && !pd[0] |=> (sc_q[0] & ~$past(statusSourceEnable[0])) == 4'h0)
    else $error("disabled source kept its flag");
  AST_READ_WAIT: assert property (
    rdFire |=> hreadyout ##0 dRead_q)
    else $error("read wait state wrong");

  COV_PD: cover property (!powerDown[0] ##1 powerDown[0]);
  COV_PULSE: cover property (!gc_q[0][1] && gc_q[0][3] && hostIrq[0]);
  COV_W1C: cover property (wrFire && dIdx_q == 8'h04 && gc_q[0][2]);
  COV_SYNC: cover property (mc_q[0] == 8'h80 && busClkFall);
endmodule
`default_nettype wire

// File: verif/host_bus_clock_model.sv
// host_bus_clock_model: host memory bus clock seen by the adapter.
// assumes run comes from the bench, changed after rising clk edges.
`timescale 1ns/100ps
`default_nettype none
module host_bus_clock_model
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  output logic hostBusClock
);
  logic [1:0] div_q;
  // quarter rate while run; parks high so no stray fall appears
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_q <= 2'h0;
      hostBusClock <= 1'b1;
    end
    else if (!run)
    begin
      div_q <= 2'h0;
      hostBusClock <= 1'b1;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      hostBusClock <= ~div_q[1];
    end
  end
endmodule
`default_nettype wire

// File: verif/slot_power_and_interrupt_control_tb.sv
// slot_power_and_interrupt_control_tb: register, pin and status tests.
// assumes one wait state on reads, none on writes, clk of 50 ns.
`timescale 1ns/100ps
`default_nettype none
module slot_power_and_interrupt_control_tb;
  localparam logic [1:0][7:0] VC = slot_ctrl_pkg::IDX_VC;
  localparam logic [1:0][7:0] GC = slot_ctrl_pkg::IDX_GC;
  localparam logic [1:0][7:0] SC = slot_ctrl_pkg::IDX_SC;
  localparam logic [1:0][7:0] MC = slot_ctrl_pkg::IDX_MC;
  logic clk, rst_b, hsel, hwrite, rdy, hresp, busClk, wrStb_b, rdStb_b, run;
  logic [31:0] haddr, hwdata, hrdata, busData;
  logic [1:0] htrans, hit, we_b, oe_b, sense1, sense0, thr, sup5, sup3;
  logic [1:0] pd, irq;
  logic [2:0] hsize;
  logic [1:0][3:0] stEvt, stEn;
  int errCount = 0;
  int comparisons = 0;
  int cycles = 0;

  slot_power_and_interrupt_control slot_power_and_interrupt_control_inst
  (
    .clk(clk), .rst_b(rst_b), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(rdy), .hreadyout(rdy), .hresp(hresp), .hrdata(hrdata),
    .hostBusClock(busClk), .hostMemoryWriteStrobe_b(wrStb_b),
    .hostMemoryReadStrobe_b(rdStb_b), .hostSlotHit(hit),
    .cardWriteEnable_b(we_b), .cardOutputEnable_b(oe_b),
    .voltageSenseInput1(sense1), .voltageSenseInput0(sense0),
    .threshold5v(thr), .supply5vEnable(sup5), .supply3v3Enable(sup3),
    .powerDown(pd), .statusEvent(stEvt), .statusSourceEnable(stEn),
    .hostIrq(irq)
  );

  host_bus_clock_model host_bus_clock_model_inst
  (
    .clk(clk), .rst_b(rst_b), .run(run), .hostBusClock(busClk)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // the whole run needs under 2000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errCount++;
      testDone();
    end
  end

  task automatic testDone();
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
    comparisons++;
    if (got !== exp)
    begin
      errCount++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask

  task automatic chkPin(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      errCount++;
      $display("unexpected at %0t: %s got %b", $time, what, got);
    end
  endtask

  // ready is looked at mid-cycle: nothing changes before the next edge
  task automatic waitReady();
    logic ok;
    ok = 1'b0;
    while (!ok)
    begin
      @(negedge clk);
      ok = (rdy === 1'b1);
      busData = hrdata;
      @(posedge clk);
    end
  endtask

  // entered just after a rising edge; returns just after the last one
  task automatic access(input logic w, input logic [7:0] idx,
                        input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'b00};
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    waitReady();
  endtask

  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp,
                       input string what);
    access(1'b0, idx, 8'h0);
    chkReg(busData, {24'h0, exp}, what);
    chkPin(hresp, 1'b0, "okay response");
  endtask

  task automatic pulse(input int s, input int b);
    stEvt[s][b] <= 1'b1;
    @(posedge clk);
    stEvt[s][b] <= 1'b0;
    @(negedge clk);
  endtask

  function automatic logic [7:0] vcExp(input int s, input logic [7:0] w);
    vcExp = w & slot_ctrl_pkg::VC_WMASK;
    vcExp[slot_ctrl_pkg::VC_SENSE1] = sense1[s];
    vcExp[slot_ctrl_pkg::VC_SENSE0] = sense0[s];
  endfunction

  initial
  begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    wrStb_b = 1'b1;
    rdStb_b = 1'b1;
    hit = 2'b00;
    sense1 = 2'b01;
    sense0 = 2'b10;
    stEvt = '0;
    stEn = '1;
    run = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    access(1'b1, 8'h01, 8'hFF);
    rdChk(8'h01, 8'h00, "unmapped");
    for (int s = 0; s < 2; s++)
    begin
      rdChk(GC[s], slot_ctrl_pkg::GC_RST, "gc reset");
      rdChk(VC[s], vcExp(s, slot_ctrl_pkg::VC_RST), "vc reset");
      // every supply code, threshold toggled alongside
      for (int c = 0; c < 4; c++)
      begin
        access(1'b1, VC[s], {5'h0, c[1], c[1:0]});
        @(negedge clk);
        chkPin(sup5[s], c == 2, "5v enable");
        chkPin(sup3[s], c == 3, "3v3 enable");
        chkPin(thr[s], c[1], "threshold");
        @(posedge clk);
      end
      access(1'b1, VC[s], 8'hFF);
      @(negedge clk);
      chkPin(pd[s], 1'b0, "pd not enabled");
      @(posedge clk);
      rdChk(VC[s], vcExp(s, 8'hFF), "vc mask");
      access(1'b1, VC[s], 8'h00);
      access(1'b1, GC[s], 8'h01);
      access(1'b1, VC[s], 8'h80);
      @(negedge clk);
      chkPin(pd[s], 1'b1, "pd entry");
      @(posedge clk);
      access(1'b1, GC[s], 8'h00);
      rdChk(GC[s], 8'h01, "gc frozen");
      access(1'b1, VC[s], 8'h83);
      rdChk(VC[s], vcExp(s, 8'h83), "vc live");
      access(1'b1, VC[s], 8'h00);
      access(1'b1, GC[s], 8'h00);
      rdChk(GC[s], 8'h00, "gc after exit");
      @(negedge clk);
      chkPin(pd[s], 1'b0, "pd exit");
      @(posedge clk);
      // clear on read, edge mode
      pulse(s, 1);
      chkPin(irq[s], 1'b1, "irq edge");
      @(posedge clk);
      rdChk(SC[s], 8'h02, "sc read");
      rdChk(SC[s], 8'h00, "sc cleared");
      @(negedge clk);
      chkPin(irq[s], 1'b0, "irq after read");
      @(posedge clk);
      // write-one-to-clear: reads must not disturb the flag
      access(1'b1, GC[s], 8'h04);
      pulse(s, 0);
      @(posedge clk);
      rdChk(SC[s], 8'h01, "sc kept");
      rdChk(SC[s], 8'h01, "sc kept again");
      @(negedge clk);
      chkPin(irq[s], 1'b1, "irq kept");
      @(posedge clk);
      access(1'b1, SC[s], 8'h01);
      @(negedge clk);
      chkPin(irq[s], 1'b0, "irq w1c");
      @(posedge clk);
      rdChk(SC[s], 8'h00, "sc w1c");
      pulse(s, 3);
      @(posedge clk);
      stEn[s][3] <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chkPin(irq[s], 1'b0, "irq source off");
      @(posedge clk);
      stEn[s][3] <= 1'b1;
      rdChk(SC[s], 8'h00, "sc source off");
      // pulse option in edge mode, then ignored in level mode
      access(1'b1, GC[s], 8'h08);
      pulse(s, 2);
      chkPin(irq[s], 1'b1, "pulse high");
      @(negedge clk);
      chkPin(irq[s], 1'b0, "pulse one cycle");
      @(posedge clk);
      rdChk(SC[s], 8'h04, "sc pulse");
      access(1'b1, GC[s], 8'h0A);
      pulse(s, 2);
      repeat (3) @(negedge clk);
      chkPin(irq[s], 1'b1, "level holds");
      @(posedge clk);
      rdChk(SC[s], 8'h04, "sc level");
      access(1'b1, GC[s], 8'h00);
    end
    // strobes on slot A, host bus clock parked high until run is set
    hit <= 2'b01;
    wrStb_b <= 1'b0;
    @(negedge clk);
    chkPin(we_b[0], 1'b0, "8-bit bypass");
    chkPin(we_b[1], 1'b1, "unhit slot idle");
    @(posedge clk);
    wrStb_b <= 1'b1;
    access(1'b1, MC[0], 8'h81);
    rdStb_b <= 1'b0;
    @(negedge clk);
    chkPin(oe_b[0], 1'b0, "inhibit bypass");
    @(posedge clk);
    rdStb_b <= 1'b1;
    access(1'b1, MC[0], 8'h80);
    wrStb_b <= 1'b0;
    rdStb_b <= 1'b0;
    repeat (4) @(negedge clk);
    chkPin(we_b[0], 1'b1, "sync waits for fall");
    chkPin(oe_b[0], 1'b1, "sync oe waits for fall");
    @(posedge clk);
    run <= 1'b1;
    repeat (8) @(negedge clk);
    chkPin(we_b[0], 1'b0, "sync after fall");
    chkPin(oe_b[0], 1'b0, "sync oe after fall");
    @(posedge clk);
    wrStb_b <= 1'b1;
    rdStb_b <= 1'b1;
    repeat (8) @(negedge clk);
    chkPin(we_b[0], 1'b1, "sync release");
    chkPin(oe_b[0], 1'b1, "sync oe release");
    testDone();
  end
endmodule
`default_nettype wire
